/* core/meds_pkg.sv */
// package: register map, status bit layout and carrier types for the drive status block
package meds_pkg;

    // register indexes, byte address is four times the index
    localparam logic [7:0] MEDS_IDX_EMERG_ACCEL = 8'h20;
    localparam logic [7:0] MEDS_IDX_INPOS_WIN   = 8'h21;
    localparam logic [7:0] MEDS_IDX_INPOS_CNT   = 8'h22;
    localparam logic [7:0] MEDS_IDX_ERR_STAT    = 8'h23;
    // own registers: limits, mask, mode control, live events
    localparam logic [7:0] MEDS_IDX_WIND_LIM    = 8'h40;
    localparam logic [7:0] MEDS_IDX_FLW_MAX     = 8'h41;
    localparam logic [7:0] MEDS_IDX_FNC_MAX     = 8'h42;
    localparam logic [7:0] MEDS_IDX_SUP_LIM     = 8'h43;
    localparam logic [7:0] MEDS_IDX_IRQ_MASK    = 8'h44;
    localparam logic [7:0] MEDS_IDX_CTRL        = 8'h45;
    localparam logic [7:0] MEDS_IDX_LIVE        = 8'h46;

    // status bit positions
    localparam int MEDS_B_WIND  = 0;
    localparam int MEDS_B_FLW   = 1;
    localparam int MEDS_B_FNC   = 2;
    localparam int MEDS_B_SUP   = 3;
    localparam int MEDS_B_INPOS = 4;
    localparam int MEDS_B_ACC   = 5;
    localparam int MEDS_B_DEC   = 6;
    localparam int MEDS_B_PLIM  = 7;
    localparam int MEDS_B_FRAME = 8;
    localparam int MEDS_NBITS   = 9;

    // reset values
    localparam logic [31:0] MEDS_RST_LIMIT = 32'hFFFF_FFFF;
    localparam logic [31:0] MEDS_RST_ZERO  = 32'h0000_0000;
    localparam logic [31:0] MEDS_RST_CNT   = 32'h0000_0001;

    // stop phase length before passive, in control cycles
    localparam logic [7:0]  MEDS_STOP_CYCLES = 8'h10;

    // measured values from the control loop, one sample per control cycle
    typedef struct packed {
        logic [31:0] wind_accum;
        logic [31:0] follow_err;
        logic [31:0] func_err;
        logic [31:0] supply_accum;
        logic [31:0] pos_dev;
        logic [31:0] vel_dev;
        logic        vel_up;
        logic        vel_down;
        logic        pos_limit_hit;
        logic        frame_err;
    } meds_meas_type;

    // drive mode state machine, gray coded along run-stop-passive
    typedef enum logic [1:0] {
        MEDS_RUN     = 2'b00,
        MEDS_STOP    = 2'b01,
        MEDS_PASSIVE = 2'b11
    } meds_mode_type;

endpackage

/* core/meds_cmp.sv */
// limit comparator bank: one flag per measured value against its limit
`timescale 1ns/1ps
module meds_cmp #(
    parameter int W = 32
) (
    // values and limits
    input  wire logic [W-1:0] wind_accum,
    input  wire logic [W-1:0] wind_lim,
    input  wire logic [W-1:0] flw_val,
    input  wire logic [W-1:0] flw_max,
    input  wire logic [W-1:0] fnc_val,
    input  wire logic [W-1:0] fnc_max,
    input  wire logic [W-1:0] sup_accum,
    input  wire logic [W-1:0] sup_lim,
    // comparison results
    output logic              wind_over,
    output logic              flw_over,
    output logic              fnc_over,
    output logic              sup_over
);
    always_comb begin
        wind_over = wind_accum > wind_lim;
        flw_over  = (flw_max != '0) && (flw_val > flw_max);
        fnc_over  = fnc_val > fnc_max;
        sup_over  = sup_accum > sup_lim;
    end
endmodule

/* core/meds_top.sv */
// drive error and status word with avalon-mm register slave
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module meds_top
    import meds_pkg::*;
#(
    parameter int CYCLE_DIV = 100
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // avalon-mm slave
    input  wire logic [9:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // control loop samples
    input  wire meds_pkg::meds_meas_type meas,
    // drive state and interrupt
    output meds_pkg::meds_mode_type mode_out,
    output logic [31:0]            emergency_accel,
    output logic                   irq
);
    import meds_pkg::*;

    // reset release through two flops
    // assertion is immediate, release comes two edges late, so no flop leaves
    // reset on an edge that lies close to the release of the pin
    logic rst_s1_q, rst_s2_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire logic rst_n = rst_s2_q;

    // byte-lane merge, used for every writable register except the control register
    // lanes with a low enable keep their old byte
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // control cycle divider: one-cycle tick
    // the tick is the only time base of the status logic: every limit compare and
    // every hit count moves on it, so all status bits share one sampling instant
    logic [15:0] div_q, div_d;
    logic        tick;
    always_comb begin
        tick  = (div_q == 16'(CYCLE_DIV - 1));
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) div_q <= 16'h0000;
        else        div_q <= div_d;
    end

    // software registers
    // limits reset to all ones, following max to zero which disables it, so that nothing fires before software sets them
    logic [31:0] accel_q, win_q, cnt_q, wlim_q, fmax_q, nmax_q, slim_q;
    logic [31:0] accel_d, win_d, cnt_d, wlim_d, fmax_d, nmax_d, slim_d;
    logic [MEDS_NBITS-1:0] mask_q, mask_d, stat_q, stat_d;
    logic        velmode_q, velmode_d;  // 1 = velocity mode
    logic        restart_d;             // write of ctrl bit 1 leaves passive

    // bus access: one wait state on every request, the answer follows in the next cycle
    // read data is captured at the end of the wait cycle, so it already stands
    // while waitrequest is low; a later capture would hand the master stale data
    logic [7:0]  idx;
    logic        acc_q, acc_d;  // high in the answer cycle
    logic        wr_go, rd_go;  // write lands, read clears, at the answer edge
    logic        rd_first;      // wait cycle of a read: read data captured here
    logic [31:0] rdata_q, rdata_d;
    assign idx      = avs_address[9:2];
    assign wr_go    = avs_write & acc_q;
    assign rd_go    = avs_read & acc_q;
    assign rd_first = avs_read & ~acc_q;
    assign avs_waitrequest = (avs_read | avs_write) & ~acc_q;
    assign avs_readdata    = rdata_q;

    // comparator results
    logic wind_over, flw_over, fnc_over, sup_over;
    meds_cmp #(.W(32)) u_cmp (
        .wind_accum (meas.wind_accum),
        .wind_lim   (wlim_q),
        .flw_val    (meas.follow_err),
        .flw_max    (fmax_q),
        .fnc_val    (meas.func_err),
        .fnc_max    (nmax_q),
        .sup_accum  (meas.supply_accum),
        .sup_lim    (slim_q),
        .wind_over  (wind_over),
        .flw_over   (flw_over),
        .fnc_over   (fnc_over),
        .sup_over   (sup_over)
    );

    // in-position / at-velocity hit counter
    logic [31:0] hits_q, hits_d;
    logic        in_win;
    logic        pos_ok;

    // drive mode machine
    meds_mode_type mode_q, mode_d;
    logic [7:0]    stop_q, stop_d;

    // live events this control cycle
    logic [MEDS_NBITS-1:0] ev;

    // register write and status next-state
    always_comb begin
        accel_d   = accel_q;
        win_d     = win_q;
        cnt_d     = cnt_q;
        wlim_d    = wlim_q;
        fmax_d    = fmax_q;
        nmax_d    = nmax_q;
        slim_d    = slim_q;
        mask_d    = mask_q;
        velmode_d = velmode_q;
        restart_d = 1'b0;
        acc_d     = (avs_read | avs_write) & ~acc_q;
        rdata_d   = rdata_q;
        // writes; the control register acts on lane 0 only
        // other lanes of a control write are ignored
        if (wr_go) begin
            if (idx == MEDS_IDX_EMERG_ACCEL) begin
                accel_d = merge(accel_q, avs_writedata, avs_byteenable);
            end else if (idx == MEDS_IDX_INPOS_WIN) begin
                win_d = merge(win_q, avs_writedata, avs_byteenable);
            end else if (idx == MEDS_IDX_INPOS_CNT) begin
                cnt_d = merge(cnt_q, avs_writedata, avs_byteenable);
            end else if (idx == MEDS_IDX_WIND_LIM) begin
                wlim_d = merge(wlim_q, avs_writedata, avs_byteenable);
            end else if (idx == MEDS_IDX_FLW_MAX) begin
                fmax_d = merge(fmax_q, avs_writedata, avs_byteenable);
            end else if (idx == MEDS_IDX_FNC_MAX) begin
                nmax_d = merge(nmax_q, avs_writedata, avs_byteenable);
            end else if (idx == MEDS_IDX_SUP_LIM) begin
                slim_d = merge(slim_q, avs_writedata, avs_byteenable);
            end else if (idx == MEDS_IDX_IRQ_MASK) begin
                mask_d = MEDS_NBITS'(merge({23'h0, mask_q}, avs_writedata, avs_byteenable));
            end else if (idx == MEDS_IDX_CTRL && avs_byteenable[0]) begin
                velmode_d = avs_writedata[0];
                restart_d = avs_writedata[1];
            end
        end
        // reads, captured in the wait cycle; unmapped reads as zero
        // the status word is taken with this cycle's tick merged in, so an event
        // landing between capture and clear is never lost
        if (rd_first) begin
            if (idx == MEDS_IDX_EMERG_ACCEL)    rdata_d = accel_q;
            else if (idx == MEDS_IDX_INPOS_WIN) rdata_d = win_q;
            else if (idx == MEDS_IDX_INPOS_CNT) rdata_d = cnt_q;
            else if (idx == MEDS_IDX_ERR_STAT)  rdata_d = {23'h0, stat_d};
            else if (idx == MEDS_IDX_WIND_LIM)  rdata_d = wlim_q;
            else if (idx == MEDS_IDX_FLW_MAX)   rdata_d = fmax_q;
            else if (idx == MEDS_IDX_FNC_MAX)   rdata_d = nmax_q;
            else if (idx == MEDS_IDX_SUP_LIM)   rdata_d = slim_q;
            else if (idx == MEDS_IDX_IRQ_MASK)  rdata_d = {23'h0, mask_q};
            else if (idx == MEDS_IDX_CTRL)      rdata_d = {28'h0, mode_q, 1'b0, velmode_q};
            else if (idx == MEDS_IDX_LIVE)      rdata_d = {23'h0, ev};
            else                                rdata_d = 32'h0000_0000;
        end
    end

    // in-window test: deviation magnitude against the window
    // the hit counter saturates instead of wrapping, so a long stay in the
    // window never drops the in-position bit again
    always_comb begin
        in_win = velmode_q ? (meas.vel_dev <= win_q)
                           : (meas.pos_dev <= win_q);
        hits_d = hits_q;
        if (tick) begin
            if (!in_win)              hits_d = 32'h0000_0000;
            else if (hits_q != '1)    hits_d = hits_q + 32'h0000_0001;
        end
        pos_ok = (hits_q >= cnt_q);
    end

    // events, sampled once per control cycle
    always_comb begin
        ev               = '0;
        ev[MEDS_B_WIND]  = wind_over;
        ev[MEDS_B_FLW]   = flw_over;
        ev[MEDS_B_FNC]   = fnc_over;
        ev[MEDS_B_SUP]   = sup_over;
        ev[MEDS_B_INPOS] = pos_ok;
        ev[MEDS_B_ACC]   = meas.vel_up;
        ev[MEDS_B_DEC]   = meas.vel_down;
        ev[MEDS_B_PLIM]  = meas.pos_limit_hit;
        ev[MEDS_B_FRAME] = meas.frame_err;
    end

    // sticky status: read clears, but a same-cycle set wins
    // bits 5 and 6 are not sticky: a read may clear them and the next tick
    // restores them, so they lag the velocity trend by at most one tick
    always_comb begin
        stat_d = stat_q;
        if (rd_go && idx == MEDS_IDX_ERR_STAT) stat_d = '0;
        if (tick) begin
            stat_d = stat_d | ev;
            // motion flags are levels, they follow the velocity trend
            stat_d[MEDS_B_ACC] = meas.vel_up;
            stat_d[MEDS_B_DEC] = meas.vel_down;
        end
    end

    // mode machine: limit hit forces stop, then passive on its own
    // the stop phase counts ticks, not clocks, so its length scales with the divider
    // a new limit hit during stop or passive does not restart the stop phase
    always_comb begin
        mode_d = mode_q;
        stop_d = stop_q;
        case (mode_q)
            MEDS_RUN: begin
                if (tick && meas.pos_limit_hit) begin
                    mode_d = MEDS_STOP;
                    stop_d = MEDS_STOP_CYCLES;
                end
            end
            MEDS_STOP: begin
                if (tick) begin
                    if (stop_q <= 8'h01) mode_d = MEDS_PASSIVE;
                    else                 stop_d = stop_q - 8'h01;
                end
            end
            MEDS_PASSIVE: begin
                // only software brings the drive back
                if (restart_d) mode_d = MEDS_RUN;
            end
            default: mode_d = MEDS_PASSIVE;
        endcase
    end

    // register all state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            accel_q   <= MEDS_RST_ZERO;
            win_q     <= MEDS_RST_ZERO;
            cnt_q     <= MEDS_RST_CNT;
            wlim_q    <= MEDS_RST_LIMIT;
            fmax_q    <= MEDS_RST_ZERO;
            nmax_q    <= MEDS_RST_LIMIT;
            slim_q    <= MEDS_RST_LIMIT;
            mask_q    <= '0;
            velmode_q <= 1'b0;
            acc_q     <= 1'b0;
            rdata_q   <= MEDS_RST_ZERO;
            hits_q    <= MEDS_RST_ZERO;
            stat_q    <= '0;
            mode_q    <= MEDS_RUN;
            stop_q    <= 8'h00;
        end else begin
            accel_q   <= accel_d;
            win_q     <= win_d;
            cnt_q     <= cnt_d;
            wlim_q    <= wlim_d;
            fmax_q    <= fmax_d;
            nmax_q    <= nmax_d;
            slim_q    <= slim_d;
            mask_q    <= mask_d;
            velmode_q <= velmode_d;
            acc_q     <= acc_d;
            rdata_q   <= rdata_d;
            hits_q    <= hits_d;
            stat_q    <= stat_d;
            mode_q    <= mode_d;
            stop_q    <= stop_d;
        end
    end

    // outputs
    // irq comes from registers only, it falls just after the clearing read's answer edge
    assign irq             = |(stat_q & mask_q);
    assign mode_out        = mode_q;
    assign emergency_accel = accel_q;

endmodule

/* sim/meds_assertions.sv */
// port checker for the drive status block, bound into the top module
`timescale 1ns/1ps
module meds_assertions
    import meds_pkg::*;
#(
    parameter int CYCLE_DIV = 100
) (
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    rst_b,
    // register bus
    input wire logic [9:0]              avs_address,
    input wire logic                    avs_read,
    input wire logic                    avs_write,
    input wire logic [31:0]             avs_writedata,
    input wire logic [3:0]              avs_byteenable,
    input wire logic [31:0]             avs_readdata,
    input wire logic                    avs_waitrequest,
    // samples, mode and interrupt
    input wire meds_pkg::meds_meas_type meas,
    input wire meds_pkg::meds_mode_type mode_out,
    input wire logic [31:0]             emergency_accel,
    input wire logic                    irq
);
    import meds_pkg::*;
    // margins allow for the tick phase and the mode register
    localparam int STOP_LAT = CYCLE_DIV + 3;
    localparam int PASS_MAX = 17 * CYCLE_DIV + 3;
    localparam int PASS_MIN = 15 * CYCLE_DIV;
    int unsigned hit_cnt;    // cycles of limit hit while running
    int unsigned stop_cnt;   // cycles spent in stop
    logic [8:0]  mask_q;     // mirror of the interrupt mask
    logic        mask_seen;  // mask reset value is not assumed
    // helper counters and mask mirror
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hit_cnt   <= 0;
            stop_cnt  <= 0;
            mask_q    <= 9'h000;
            mask_seen <= 1'b0;
        end else begin
            hit_cnt  <= (meas.pos_limit_hit && mode_out == MEDS_RUN) ? hit_cnt + 1 : 0;
            stop_cnt <= (mode_out == MEDS_STOP) ? stop_cnt + 1 : 0;
            if (avs_write && !avs_waitrequest && avs_address == 10'h110) begin
                mask_q    <= avs_writedata[8:0];
                mask_seen <= 1'b1;
            end
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_wait_first: assert property (($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest)
        else $error("no wait state on a new request");
    a_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 10'h3FC
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero");
    a_emerg_copy: assert property (avs_write && !avs_waitrequest && avs_address == 10'h080
        && avs_byteenable == 4'hF |=> emergency_accel == $past(avs_writedata))
        else $error("emergency accel output not updated");
    a_stop_bound: assert property (hit_cnt <= STOP_LAT)
        else $error("limit hit did not stop the drive");
    a_passive_late: assert property (stop_cnt <= PASS_MAX)
        else $error("stop phase too long");
    a_passive_early: assert property (mode_out == MEDS_PASSIVE && $past(mode_out) == MEDS_STOP
        |-> stop_cnt >= PASS_MIN)
        else $error("stop phase too short");
    a_passive_hold: assert property (mode_out == MEDS_PASSIVE |=> mode_out == MEDS_PASSIVE
        || $past(avs_write, 1) || $past(avs_write, 2))
        else $error("passive left without a host write");
    a_mode_code: assert property (mode_out != 2'b10)
        else $error("illegal mode code");
    a_irq_masked: assert property (mask_seen && mask_q == 9'h000 && $past(mask_q) == 9'h000
        |-> !irq)
        else $error("interrupt with all sources masked");
    c_passive: cover property (mode_out == MEDS_PASSIVE);
    c_irq: cover property (irq);
    c_stat_read: cover property (avs_read && !avs_waitrequest && avs_address == 10'h08C);
endmodule
bind meds_top meds_assertions #(.CYCLE_DIV(CYCLE_DIV)) meds_assertions_inst (
    .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas(meas),
    .mode_out(mode_out), .emergency_accel(emergency_accel), .irq(irq)
);

/* sim/meds_host.sv */
// host model: avalon-mm master doing single register transfers
`timescale 1ns/1ps
module meds_host (
    // clock
    input  wire logic        mclk,
    // avalon-mm master side
    output logic [9:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // idle bus at time zero
    initial begin
        avs_address    = 10'h000;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hF;
    end
    // one transfer, held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !w;
        avs_write     <= w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        // released lines must not look like the last transfer
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask
endmodule

/* sim/meds_top_test.sv */
// self-checking bench for the drive error and status block
`timescale 1ns/1ps
module meds_top_test;
    import meds_pkg::*;
    localparam int DIV = 4;  // short control tick keeps the run brief
    localparam logic [9:0]  RA [8] = '{10'h080, 10'h084, 10'h088, 10'h100,
                                       10'h104, 10'h108, 10'h10C, 10'h3FC};
    localparam logic [31:0] RV [8] = '{32'h0, 32'h0, 32'h1, 32'hFFFF_FFFF,
                                       32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0};
    logic          mclk;
    logic          rst_b;
    logic [9:0]    avs_address;
    logic          avs_read;
    logic          avs_write;
    logic [31:0]   avs_writedata;
    logic [3:0]    avs_byteenable;
    logic [31:0]   avs_readdata;
    logic          avs_waitrequest;
    meds_meas_type meas;
    meds_meas_type quiet;    // no events, deviation far outside window
    meds_meas_type m;
    meds_mode_type mode_out;
    logic [31:0]   emergency_accel;
    logic          irq;
    logic [31:0]   lim [4];  // winding, following, function, supply
    logic [31:0]   win;
    logic [31:0]   q;
    logic          vmode;
    int            miscompares;
    int            checks;
    int            cycles;
    meds_top #(.CYCLE_DIV(DIV)) meds_top_inst (
        .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .meas(meas), .mode_out(mode_out),
        .emergency_accel(emergency_accel), .irq(irq));
    meds_host meds_host_inst (
        .mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] x;
        meds_host_inst.xfer(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        meds_host_inst.xfer(1'b0, a, 32'h0, d);
    endtask
    // whole control ticks, period fixed by the divider
    task automatic ticks(input int n);
        repeat (n * DIV) @(posedge mclk);
    endtask
    // a value at, just under or just over a limit
    function automatic logic [31:0] near(input logic [31:0] l);
        return l + 32'($urandom_range(2)) - 32'h1;
    endfunction
    // status expected from one steady sample; strict greater-than
    function automatic logic [31:0] exp_stat(input meds_meas_type s);
        logic [31:0] e;
        e = 32'h0000_0000;
        e[MEDS_B_WIND]  = s.wind_accum > lim[0];
        e[MEDS_B_FLW]   = lim[1] != 32'h0 && s.follow_err > lim[1];
        e[MEDS_B_FNC]   = s.func_err > lim[2];
        e[MEDS_B_SUP]   = s.supply_accum > lim[3];
        e[MEDS_B_INPOS] = (vmode ? s.vel_dev : s.pos_dev) <= win;
        e[MEDS_B_ACC]   = s.vel_up;
        e[MEDS_B_DEC]   = s.vel_down;
        e[MEDS_B_PLIM]  = s.pos_limit_hit;
        e[MEDS_B_FRAME] = s.frame_err;
        return e;
    endfunction
    // clear under quiet samples, hold a sample, read the status word
    task automatic probe(input meds_meas_type s);
        meas <= quiet;
        ticks(3);
        rd(10'h08C, q);
        meas <= s;
        ticks(6);
        rd(10'h08C, q);
        check("status", q, exp_stat(s));
    endtask
    initial begin
        miscompares = 0;
        checks = 0;
        cycles = 0;
        rst_b = 1'b0;
        quiet = '0;
        quiet.pos_dev = 32'hFFFF_FFFF;
        quiet.vel_dev = 32'hFFFF_FFFF;
        meas = quiet;
        lim = '{32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
        win = 32'h0;
        vmode = 1'b0;
        void'($urandom(2));
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        // reset values, unmapped place last
        for (int i = 0; i < 8; i++) begin
            rd(RA[i], q);
            check("reset value", q, RV[i]);
        end
        // all interrupt sources masked while the random samples run
        wr(10'h110, 32'h0);
        // following check disabled at zero; winding exactly at limit
        m = quiet;
        m.follow_err = 32'hFFFF_FFFF;
        m.wind_accum = 32'hFFFF_FFFF;
        probe(m);
        q = $urandom;
        wr(10'h080, q);
        @(posedge mclk);
        check("emergency accel", emergency_accel, q);
        // random limits and samples around them
        for (int i = 0; i < 12; i++) begin
            for (int k = 0; k < 4; k++) begin
                lim[k] = (k == 1 && i % 3 == 0) ? 32'h0 : $urandom;
                wr(10'h100 + 10'(4 * k), lim[k]);
            end
            win = $urandom_range(8);
            wr(10'h084, win);
            wr(10'h088, 32'($urandom_range(3, 1)));
            vmode = 1'($urandom_range(1));
            wr(10'h114, {31'h0, vmode});
            m = quiet;
            m.wind_accum = near(lim[0]);
            m.follow_err = near(lim[1]);
            m.func_err = near(lim[2]);
            m.supply_accum = near(lim[3]);
            m.pos_dev = $urandom_range(12);
            m.vel_dev = $urandom_range(12);
            {m.vel_up, m.vel_down, m.frame_err} = 3'($urandom);
            probe(m);
        end
        // software limit: stop, then passive on its own, then restart
        m = quiet;
        m.pos_limit_hit = 1'b1;
        meas <= m;
        ticks(2);
        check("mode", 32'(mode_out), 32'(MEDS_STOP));
        meas <= quiet;
        ticks(12);
        check("mode", 32'(mode_out), 32'(MEDS_STOP));
        ticks(6);
        check("mode", 32'(mode_out), 32'(MEDS_PASSIVE));
        rd(10'h08C, q);
        check("limit bit", q & 32'h80, 32'h80);
        wr(10'h114, 32'h2);
        ticks(1);
        check("mode", 32'(mode_out), 32'(MEDS_RUN));
        // interrupt: masked, raised, cleared by the status read
        wr(10'h110, 32'h1);
        m = quiet;
        m.frame_err = 1'b1;
        meas <= m;
        ticks(2);
        check("irq", 32'(irq), 32'h0);
        wr(10'h110, 32'h100);
        ticks(1);
        check("irq", 32'(irq), 32'h1);
        meas <= quiet;
        rd(10'h08C, q);
        ticks(1);
        check("irq", 32'(irq), 32'h0);
        tally_and_finish();
    end
endmodule
